// File: rtl/scd_pkg.sv
/*
 * Shared constants and types of the serial command decoder.
 * Assumes a 16-bit serial frame, MSB first, framed by an active-low select.
 */
package scd_pkg;

    localparam int FRAME_BITS = 16;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 12;
    localparam int KEY_HI = 11;
    localparam int KEY_LO = 8;
    localparam int HIGH_HI = 7;
    localparam int HIGH_LO = 4;
    localparam int LOW_HI = 3;
    localparam int LOW_LO = 0;
    localparam int RW_BIT = 15;
    localparam int CHANNELS = 10;

    localparam logic [2:0] CMD_SPACE = 3'h0;
    localparam logic [3:0] CMD_KEY = 4'h7;

    localparam logic [3:0] LOW_NOP = 4'h0;
    localparam logic [3:0] LOW_RET_SUMMARY = 4'h1;
    localparam logic [3:0] LOW_RET_STATUS = 4'h2;
    localparam logic [3:0] LOW_PATTERN_ECHO = 4'h4;
    localparam logic [3:0] LOW_INPUT_PINS = 4'h8;

    localparam logic [3:0] HIGH_NOP = 4'h0;
    localparam logic [3:0] HIGH_CLEAR_STATUS = 4'h1;

    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] RESET_FEEDBACK = 16'h0000;

    // Status byte field positions.
    localparam int ST_SUM_LO = 0;
    localparam int ST_SUM_HI = 1;
    localparam int ST_UV_LOGIC = 2;
    localparam int ST_UV_ANALOG = 3;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_CMD_ERR = 5;

    typedef enum logic [4:0] {
        SCD_FB_ZERO = 5'b00001,
        SCD_FB_SUMMARY = 5'b00010,
        SCD_FB_STATUS = 5'b00100,
        SCD_FB_ECHO = 5'b01000,
        SCD_FB_PINS = 5'b10000
    } scd_fb_t;

    typedef struct packed {
        logic [15:0] word;
        logic valid_length;
    } scd_frame_t;

    // Decoded result of one frame, handed from the link domain.
    typedef struct packed {
        logic is_command;
        logic is_write;
        logic bad_frame;
        logic bad_command;
        logic clear_status;
        scd_fb_t feedback;
        logic [15:0] word;
    } scd_decode_t;

endpackage : scd_pkg

// File: rtl/scd_sync.sv
/*
 * Two-stage synchroniser for a bus of levels.
 * Assumes each bit changes slowly relative to the destination clock.
 */
`timescale 1ns/1ps
module scd_sync #(
    parameter int WIDTH = 1
) (
    // Destination domain.
    input wire logic clk,
    input wire logic rst_n,
    // Data.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
            dout <= '0;
        end else begin
            stage <= din;
            dout <= stage;
        end
    end
endmodule : scd_sync

// File: rtl/scd_decoder.sv
/*
 * Serial command decoder: shifts in frames on the link clock, decodes
 * the command space and shifts the feedback out in the next frame.
 * Assumes the master samples data_out on the rising link clock edge
 * and changes data_in on the falling edge; data_out changes on falling.
 */
`timescale 1ns/1ps
module scd_decoder #(
    parameter int CHANNELS = scd_pkg::CHANNELS
) (
    // System clock domain.
    input wire logic clk,
    input wire logic rst_n,
    // Serial link, clocked by the master.
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic data_in,
    output logic data_out,
    output logic data_out_en,
    // Device state observed by the feedback.
    input wire logic [CHANNELS-1:0] channel_fault,
    input wire logic [CHANNELS-1:0] input_pins,
    input wire logic uv_logic,
    input wire logic uv_analog,
    // Decoded frame result in the system domain.
    output logic frame_done,
    output logic [15:0] write_word,
    output logic write_strobe,
    output logic [7:0] status_byte,
    output logic reset_flag,
    output logic comm_error
);
    // Link domain state.
    typedef struct packed {
        logic [15:0] shift_in;
        logic [4:0] bit_count;
    } scd_link_t;

    // System domain state.
    typedef struct packed {
        logic [2:0] toggle_pipe;
        logic [15:0] feedback;
        logic reset_flag;
        logic frame_err;
        logic cmd_err;
        logic frame_done;
        logic write_strobe;
        logic [15:0] write_word;
        logic [7:0] status_byte;
        logic out_en;
    } scd_sys_t;

    scd_link_t lk;
    scd_link_t next_lk;
    scd_sys_t sy;
    scd_sys_t next_sy;
    logic [CHANNELS-1:0] fault_s;
    logic [CHANNELS-1:0] pins_s;
    logic [1:0] uv_s;
    logic [2:0] sel_s;
    logic [15:0] feedback_s;
    // These live on other edges of the link, so they stay out of the struct.
    logic [15:0] out_shift;
    logic done_toggle;
    scd_pkg::scd_decode_t result;

    function automatic logic one_hot_or_zero(input logic [3:0] v);
        return (v & (v - 4'h1)) == 4'h0;
    endfunction : one_hot_or_zero

    function automatic scd_pkg::scd_decode_t decode(input logic [15:0] w, input logic ok);
        scd_pkg::scd_decode_t d;
        logic [3:0] lo;
        logic [3:0] hi;
        logic key_ok;
        logic lo_ok;
        logic hi_ok;
        d = '0;
        lo = w[scd_pkg::LOW_HI:scd_pkg::LOW_LO];
        hi = w[scd_pkg::HIGH_HI:scd_pkg::HIGH_LO];
        d.word = w;
        d.bad_frame = !ok;
        d.is_write = !w[scd_pkg::RW_BIT];
        d.is_command = ok && w[scd_pkg::ADDR_HI:scd_pkg::ADDR_LO] == scd_pkg::CMD_SPACE;
        d.feedback = scd_pkg::SCD_FB_ZERO;
        key_ok = w[scd_pkg::KEY_HI:scd_pkg::KEY_LO] == scd_pkg::CMD_KEY;
        // More than one bit set in a group is an invalid code and voids the whole command.
        lo_ok = one_hot_or_zero(lo);
        hi_ok = hi == scd_pkg::HIGH_NOP || hi == scd_pkg::HIGH_CLEAR_STATUS;
        if (!ok) begin
            d.feedback = scd_pkg::SCD_FB_ZERO;
        end else if (d.is_command) begin
            if (!d.is_write) begin
                d.feedback = scd_pkg::SCD_FB_ZERO;
            end else if (!key_ok || !lo_ok || !hi_ok) begin
                d.bad_command = 1'b1;
            end else begin
                d.clear_status = hi == scd_pkg::HIGH_CLEAR_STATUS;
                case (lo)
                    scd_pkg::LOW_RET_SUMMARY: d.feedback = scd_pkg::SCD_FB_SUMMARY;
                    scd_pkg::LOW_RET_STATUS: d.feedback = scd_pkg::SCD_FB_STATUS;
                    scd_pkg::LOW_PATTERN_ECHO: d.feedback = scd_pkg::SCD_FB_ECHO;
                    scd_pkg::LOW_INPUT_PINS: d.feedback = scd_pkg::SCD_FB_PINS;
                    default: d.feedback = scd_pkg::SCD_FB_ZERO;
                endcase
            end
        end else if (d.is_write) begin
            d.feedback = scd_pkg::SCD_FB_SUMMARY;
        end
        return d;
    endfunction : decode

    // Link domain: shift in on rising edge, shift out on falling edge.
    always_comb begin
        next_lk = lk;
        if (!link_sel_n) begin
            next_lk.shift_in = {lk.shift_in[14:0], data_in};
            next_lk.bit_count = lk.bit_count + 5'h1;
        end
    end

    // Bit count and shift register reset at each frame close via select and stay reset until the next frame.
    always_ff @(posedge link_clk or posedge link_sel_n) begin
        if (link_sel_n) begin
            lk.shift_in <= '0;
            lk.bit_count <= '0;
        end else begin
            lk.shift_in <= next_lk.shift_in;
            lk.bit_count <= next_lk.bit_count;
        end
    end

    // Frame close: decode and hand over by toggle.
    always_ff @(posedge link_sel_n or negedge rst_n) begin
        if (!rst_n) begin
            done_toggle <= 1'b0;
            result <= '0;
        end else begin
            result <= decode(lk.shift_in, lk.bit_count == 5'd16);
            done_toggle <= !done_toggle;
        end
    end

    // Bits 14 to 0 move on the falling link clock. Bit 15 comes from the held
    // word before the first edge, since the clock stands still between frames.
    always_ff @(negedge link_clk) begin
        if (lk.bit_count == 5'h1) begin
            out_shift <= {feedback_s[14:0], 1'b0};
        end else begin
            out_shift <= {out_shift[14:0], 1'b0};
        end
    end

    // The feedback word is held stable in the system domain between frames.
    assign feedback_s = sy.feedback;

    // Faults, pins and both undervoltage inputs are brought into the system domain.
    scd_sync #(.WIDTH(2 * CHANNELS + 2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({channel_fault, input_pins, uv_logic, uv_analog}),
        .dout({fault_s, pins_s, uv_s})
    );

    always_comb begin
        logic [15:0] summary;
        logic [7:0] status;
        logic event_now;
        logic [15:0] fb_word;
        summary = '0;
        fb_word = '0;
        status = '0;
        event_now = 1'b0;
        next_sy = sy;
        next_sy.toggle_pipe = {sy.toggle_pipe[1:0], done_toggle};
        next_sy.frame_done = 1'b0;
        next_sy.write_strobe = 1'b0;
        next_sy.out_en = sel_s[1];
        summary[CHANNELS-1:0] = fault_s;
        summary[15] = ^fault_s;
        status[scd_pkg::ST_SUM_LO] = |fault_s[5:0];
        status[scd_pkg::ST_SUM_HI] = |fault_s[CHANNELS-1:6];
        status[scd_pkg::ST_UV_LOGIC] = sy.reset_flag;
        status[scd_pkg::ST_UV_ANALOG] = uv_s[0];
        status[scd_pkg::ST_FRAME_ERR] = sy.frame_err;
        status[scd_pkg::ST_CMD_ERR] = sy.cmd_err;
        next_sy.status_byte = status;
        event_now = sy.toggle_pipe[2] != sy.toggle_pipe[1];
        if (event_now) begin
            next_sy.frame_done = 1'b1;
            // Clear before set, so an error in the same frame stays latched.
            if (result.clear_status) begin
                next_sy.reset_flag = uv_s[1];
                next_sy.frame_err = 1'b0;
                next_sy.cmd_err = 1'b0;
            end
            if (result.bad_frame) begin
                next_sy.frame_err = 1'b1;
            end
            if (result.bad_command) begin
                next_sy.cmd_err = 1'b1;
            end
            if (!result.is_command && result.is_write && !result.bad_frame) begin
                next_sy.write_strobe = 1'b1;
                next_sy.write_word = result.word;
            end
            case (result.feedback)
                scd_pkg::SCD_FB_SUMMARY: fb_word = summary;
                scd_pkg::SCD_FB_STATUS: fb_word = {8'h00, status};
                scd_pkg::SCD_FB_ECHO: fb_word = {1'b0, result.word[14:0]};
                scd_pkg::SCD_FB_PINS: fb_word = {6'h00, pins_s};
                default: fb_word = scd_pkg::ZERO_WORD;
            endcase
            // The check bit gives every feedback word even parity.
            fb_word[15] = ^fb_word[14:0];
            next_sy.feedback = fb_word;
        end
        if (uv_s[1]) begin
            next_sy.reset_flag = 1'b1;
        end
    end

    scd_sync #(.WIDTH(1)) u_sel_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(!link_sel_n),
        .dout(sel_s[1])
    );
    assign sel_s[0] = 1'b0;
    assign sel_s[2] = 1'b0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy <= '0;
            sy.reset_flag <= 1'b1;
            sy.feedback <= scd_pkg::RESET_FEEDBACK;
        end else begin
            sy <= next_sy;
        end
    end

    assign data_out = (lk.bit_count == 5'h0) ? feedback_s[15] : out_shift[15];
    assign data_out_en = !link_sel_n;
    assign frame_done = sy.frame_done;
    assign write_strobe = sy.write_strobe;
    assign write_word = sy.write_word;
    assign status_byte = sy.status_byte;
    assign reset_flag = sy.reset_flag;
    assign comm_error = sy.cmd_err;

    chk_nop_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(sy.toggle_pipe[2]) && result.feedback == scd_pkg::SCD_FB_ZERO
        |=> sy.feedback == scd_pkg::ZERO_WORD)
        else $error("nop feedback not zero");
    chk_bad_sets_err: assert property (@(posedge clk) disable iff (!rst_n)
        (sy.toggle_pipe[2] != sy.toggle_pipe[1]) && result.bad_command |=> sy.cmd_err)
        else $error("bad command did not set error");
    chk_status_zero: assert property (@(posedge clk) disable iff (!rst_n)
        sy.status_byte[7:6] == 2'b00)
        else $error("status high bits not zero");
    chk_summary_top: assert property (@(posedge clk) disable iff (!rst_n)
        (sy.toggle_pipe[2] != sy.toggle_pipe[1])
        && (result.feedback == scd_pkg::SCD_FB_SUMMARY
        || result.feedback == scd_pkg::SCD_FB_STATUS)
        |=> sy.feedback[14:10] == 5'h00)
        else $error("summary zero field broken");
    chk_clear_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (sy.toggle_pipe[2] != sy.toggle_pipe[1]) && result.clear_status
        |=> !sy.frame_err && !sy.cmd_err)
        else $error("status clear left error flags set");
    chk_write_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        (sy.toggle_pipe[2] != sy.toggle_pipe[1]) && !result.is_command
        && result.is_write && !result.bad_frame
        |=> sy.write_strobe && sy.write_word == $past(result.word))
        else $error("write frame gave no strobe");
endmodule : scd_decoder

// File: bench/scd_master_model.sv
/*
 * Behavioural serial master that frames words towards the command decoder.
 * Assumes the device samples data_in on the rising link clock and drives
 * data_out on the falling one while data_out_en is high.
 */
`timescale 1ns/1ps
module scd_master_model (
    // Link towards the device.
    output logic link_clk,
    output logic link_sel_n,
    output logic data_in,
    // Feedback from the device.
    input wire logic data_out,
    input wire logic data_out_en
);

    initial begin
        link_clk = 1'b0;
        link_sel_n = 1'b1;
        data_in = 1'b0;
    end

    // The clock stands still between frames; an undriven feedback line reads
    // as unknown so that a silent device can never pass for a match.
    task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        link_sel_n = 1'b0;
        data_in = w[15];
        #80;
        for (int i = 0; i < nbits; i++) begin
            rx = {rx[14:0], data_out_en ? data_out : 1'bx};
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
            if (i < nbits - 1) data_in = w[14 - i];
            #80;
        end
        link_sel_n = 1'b1;
        data_in = ~data_in;
    endtask : xfer

endmodule : scd_master_model

// File: bench/tb_spi_command_decoder.sv
/*
 * Self-checking bench of the serial command decoder.
 * Assumes the master model drives the link; expectations come from bench functions.
 */
`timescale 1ns/1ps
module tb_spi_command_decoder;
    logic clk, rst_n, link_clk, link_sel_n, data_in, data_out, data_out_en;
    logic [9:0] channel_fault, input_pins;
    logic uv_logic, uv_analog, frame_done, write_strobe, reset_flag, comm_error;
    logic [15:0] write_word, exp_fb, exp_mask, rx, w;
    logic [7:0] status_byte;
    logic seen_done, seen_wr, ce, fe, rf;
    logic [3:0] lows [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    logic [15:0] bad [4] = '{16'h0713, 16'h0730, 16'h0601, 16'h0705};
    int n_fail, total_checks, seed;

    scd_decoder i_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
        .link_sel_n(link_sel_n), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en), .channel_fault(channel_fault), .input_pins(input_pins),
        .uv_logic(uv_logic), .uv_analog(uv_analog), .frame_done(frame_done),
        .write_word(write_word), .write_strobe(write_strobe), .status_byte(status_byte),
        .reset_flag(reset_flag), .comm_error(comm_error));
    scd_master_model i_master (.link_clk(link_clk), .link_sel_n(link_sel_n),
        .data_in(data_in), .data_out(data_out), .data_out_en(data_out_en));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (frame_done === 1'b1) seen_done <= 1'b1;
        if (write_strobe === 1'b1) seen_wr <= 1'b1;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [15:0] exp, got, msk);
        total_checks++;
        if ((got & msk) !== (exp & msk)) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp & msk, got & msk);
        end
    endtask : check

    // Feedback due in the frame after w, with bit 15 as XOR of the rest.
    function automatic logic [15:0] resp(input logic [15:0] w);
        logic [15:0] r;
        r = 16'h0000;
        if (w[14:12] != 3'h0) r = w[15] ? 16'h0000 : {6'h00, channel_fault};
        else if (!w[15]) begin
            case (w[3:0])
                4'h1: r = {6'h00, channel_fault};
                4'h2: r = {10'h000, ce, fe, 1'b0, rf, |channel_fault[9:6], |channel_fault[5:0]};
                4'h4: r = {1'b0, w[14:0]};
                4'h8: r = {6'h00, input_pins};
                default: r = 16'h0000;
            endcase
        end
        r[15] = ^r[14:0];
        return r;
    endfunction : resp

    task automatic frame(input logic [15:0] wd, input int nbits, input logic [15:0] msk);
        logic [15:0] nexp;
        nexp = resp(wd);
        seen_done = 1'b0;
        seen_wr = 1'b0;
        #3.3;
        i_master.xfer(wd, nbits, rx);
        if (nbits == 16) check("feedback", exp_fb, rx, exp_mask);
        repeat (40) if (!seen_done) @(posedge clk);
        if (nbits == 16) check("frame done", 16'h0001, {15'h0000, seen_done}, 16'hffff);
        repeat (6) @(posedge clk);
        exp_fb = nexp;
        exp_mask = (nbits == 16) ? msk : 16'h0000;
    endtask : frame

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        ce = 1'b0;
        fe = 1'b0;
        rf = 1'b1;
        exp_fb = 16'h0000;
        exp_mask = 16'hffff;
        repeat (4) @(posedge clk);
    endtask : do_reset

    initial begin
        #500_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        seed = 32'hd013;
        rst_n = 1'b0;
        channel_fault = 10'h000;
        input_pins = 10'h000;
        uv_logic = 1'b0;
        uv_analog = 1'b0;
        n_fail = 0;
        total_checks = 0;
        do_reset();
        check("reset flag", 16'h0001, {15'h0000, reset_flag}, 16'hffff);
        frame(16'h0700, 16, 16'hffff);
        foreach (lows[i]) begin
            @(posedge clk);
            #1 channel_fault = $random(seed);
            input_pins = $random(seed);
            repeat (4) @(posedge clk);
            frame({8'h07, 4'h0, lows[i]}, 16, lows[i] == 4'h2 ? 16'hfff3 : 16'hffff);
        end
        foreach (bad[i]) begin
            frame(bad[i], 16, 16'h0000);
            check("comm error", 16'h0001, {15'h0000, comm_error}, 16'hffff);
            if (i == 0) check("reset kept", 16'h0001, {15'h0000, reset_flag}, 16'hffff);
            ce = 1'b1;
            frame(16'h0702, 16, 16'hfff3);
            frame(16'h0710, 16, 16'hffff);
            ce = 1'b0;
            rf = 1'b0;
            check("comm cleared", 16'h0000, {15'h0000, comm_error}, 16'hffff);
            check("reset cleared", 16'h0000, {15'h0000, reset_flag}, 16'hffff);
        end
        frame(16'h0702, 12, 16'h0000);
        check("status byte", 16'h0010, {8'h00, status_byte}, 16'h00f0);
        fe = 1'b1;
        frame(16'h0702, 16, 16'hfff3);
        frame(16'h0710, 16, 16'hffff);
        fe = 1'b0;
        w = 16'h2abc;
        frame(w, 16, 16'hffff);
        check("write strobe", 16'h0001, {15'h0000, seen_wr}, 16'hffff);
        check("write word", w, write_word, 16'hffff);
        frame(16'h8704, 16, 16'hffff);
        exp_fb = 16'h0000;
        frame(16'h0700, 16, 16'hffff);
        do_reset();
        uv_logic = 1'b1;
        frame(16'h0710, 16, 16'hffff);
        check("reset persists", 16'h0001, {15'h0000, reset_flag}, 16'hffff);
        uv_logic = 1'b0;
        repeat (4) @(posedge clk);
        frame(16'h0711, 16, 16'hffff);
        rf = 1'b0;
        check("reset cleared", 16'h0000, {15'h0000, reset_flag}, 16'hffff);
        repeat (12) begin
            @(posedge clk);
            #1 channel_fault = $random(seed);
            input_pins = $random(seed);
            repeat (4) @(posedge clk);
            w = {8'h07, 4'h0, lows[$unsigned($random(seed)) % 5]};
            frame(w, 16, w[3:0] == 4'h2 ? 16'hfff3 : 16'hffff);
        end
        frame(16'h0700, 16, 16'hffff);
        give_verdict();
    end

endmodule : tb_spi_command_decoder
